/* File: logic/ppl_consts.svh */
// Register offsets, field positions, reset values and timing counts of the pin block.
// Definitions only; included by bare name from every design file that needs them.
`ifndef PPL_CONSTS_SVH
`define PPL_CONSTS_SVH
`define PPL_CLK_NS       40
`define PPL_PULSE_NS     30000
`define PPL_PULSE_CYC    ((`PPL_PULSE_NS + `PPL_CLK_NS - 1) / `PPL_CLK_NS)
`define PPL_PWM_W        24
`define PPL_ADDR_W       5
`define PPL_OFF_CFG      5'h00
`define PPL_OFF_P1PER    5'h04
`define PPL_OFF_P1DUTY   5'h08
`define PPL_OFF_P2PER    5'h0C
`define PPL_OFF_P2DUTY   5'h10
`define PPL_OFF_STATUS   5'h14
`define PPL_OFF_EVENT    5'h18
`define PPL_OFF_CMD      5'h1C
`define PPL_P1_FUNC_LSB  0
`define PPL_P1_INV       2
`define PPL_P1_OSEL_LSB  3
`define PPL_P2_FUNC_LSB  8
`define PPL_P2_INV       10
`define PPL_P2_OSEL_LSB  11
`define PPL_CFG_MASK     32'h0000_1F1F
`define PPL_CFG_RST      32'h0000_0000
`define PPL_PWM_RST      32'h0000_0000
`define PPL_ST_PROT      0
`define PPL_ST_IN1       1
`define PPL_ST_IN2       2
`define PPL_ST_OUTON     3
`define PPL_ST_PULSE     4
`define PPL_EV_CLR       0
`define PPL_EV_SENT      1
`define PPL_CMD_CLR      0
`endif

/* File: logic/ppl_pin_sync.sv */
// Two-flop synchroniser for the pin inputs.
// Assumes the pins are asynchronous to clock and idle high.
`default_nettype none
module ppl_pin_sync #(
	parameter int W = 2
) (
	input  wire logic         clock,	// System clock.
	input  wire logic         rst,	// Asynchronous reset, active high.
	input  wire logic [W-1:0] din,	// Raw pin levels.
	output logic      [W-1:0] dout	// Synchronised levels.
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// Only the second stage is read, so metastability never reaches logic.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_reg <= '1;
			sync_reg <= '1;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
		end
	end

	assign dout = sync_reg;
endmodule // ppl_pin_sync
`default_nettype wire

/* File: logic/ppl_pkg.sv */
// Types shared by the pin block: pin functions, output choices, pulse states.
// Assumes nothing of its surroundings.
`default_nettype none
package ppl_pkg;
	typedef enum logic [1:0] {
		PPL_FN_PROT = 2'b00,
		PPL_FN_IN   = 2'b01,
		PPL_FN_OUT  = 2'b10
	} ppl_func_t;
	typedef enum logic [1:0] {
		PPL_OS_FALSE = 2'b00,
		PPL_OS_TRUE  = 2'b01,
		PPL_OS_PWM   = 2'b10
	} ppl_osel_t;
	typedef enum logic {
		PPL_PULSE_IDLE  = 1'b0,
		PPL_PULSE_DRIVE = 1'b1
	} ppl_pulse_t;
endpackage
`default_nettype wire

/* File: logic/ppl_pwm.sv */
// PWM generator producing a logic wave of programmable period and duty.
// Assumes period and duty come from registers on the same clock.
`default_nettype none
module ppl_pwm #(
	parameter int W = 24
) (
	input  wire logic clock,	// System clock.
	input  wire logic rst,	// Asynchronous reset, active high.
	ppl_pwm_if.gen    bus	// Settings in, wave out.
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	logic         wave_reg;
	logic         wave_next;
	logic         wrap;

	// Wrap also when the period is shortened below the running count.
	assign wrap      = (bus.period == '0) || (cnt_reg >= (bus.period - {{(W-1){1'b0}}, 1'b1}));
	assign cnt_next  = wrap ? '0 : (cnt_reg + {{(W-1){1'b0}}, 1'b1});
	assign wave_next = (bus.period != '0) && (cnt_reg < bus.duty);

	// Counter and registered wave.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_reg  <= '0;
			wave_reg <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			wave_reg <= wave_next;
		end
	end

	assign bus.wave = wave_reg;
endmodule // ppl_pwm
`default_nettype wire

/* File: logic/ppl_pwm_if.sv */
// Link between the pin logic and one PWM generator.
// Assumes both ends run on the same clock.
`default_nettype none
interface ppl_pwm_if #(
	parameter int W = 24
);
	logic [W-1:0] period;	// Period in clocks; zero stops the wave.
	logic [W-1:0] duty;	// Clocks per period at logic 1.
	logic         wave;	// Logic value of the wave.
	modport gen (input period, input duty, output wave);
	modport user (output period, output duty, input wave);
endinterface
`default_nettype wire

/* File: logic/ppl_top.sv */
// Logic of the two multi-function pins: protection clear and protection state.
// Assumes an Avalon-MM master on clock, pads that resolve pinXOut and pinXOe,
// and protection and output-switch signals from logic on the same clock.
//
// Behaviour
// - Pin one: clear, level input or output.
// - Pin two: state, level input or output.
// - Per-pin invert, default off, flips all senses.
// - Output true drives logic 1, low uninverted.
// - Output false drives logic 0, high uninverted.
// - Output may be 1, 0 or PWM.
// - Input mode reports the detected logic value.
// - Clear mode pin is both input and output.
// - Valid pulse clears latched protection.
// - Pulse low phase at least 30 us.
// - Pulse out on off-to-on after release.
// - State pin high unprotected, low protected.
// - Inverted state pin is exact complement.
// - Pulses are high-to-low, active phase low.
`default_nettype none
`include "ppl_consts.svh"

module ppl_top
	import ppl_pkg::*;
#(
	parameter int PULSE_CYC = `PPL_PULSE_CYC,	// Clocks of a valid pulse.
	parameter int PW        = `PPL_PWM_W	// Width of the PWM settings.
) (
	input  wire logic                   clock,	// System clock, 25 MHz.
	input  wire logic                   rst,	// Asynchronous reset, active high.
	input  wire logic [`PPL_ADDR_W-1:0] avs_address,	// Byte address.
	input  wire logic                   avs_read,	// Read request.
	input  wire logic                   avs_write,	// Write request.
	input  wire logic [31:0]            avs_writedata,	// Write data.
	input  wire logic [3:0]             avs_byteenable,	// Byte lanes of a write.
	output logic      [31:0]            avs_readdata,	// Read data.
	output logic                        avs_waitrequest,	// Stall while high.
	input  wire logic                   protectTrip,	// Protection event, sets latch.
	input  wire logic                   outputOn,	// Output switch state.
	input  wire logic                   pin1In,	// Level on pin one.
	output logic                        pin1Out,	// Level driven on pin one.
	output logic                        pin1Oe,	// Pin one driven while high.
	input  wire logic                   pin2In,	// Level on pin two.
	output logic                        pin2Out,	// Level driven on pin two.
	output logic                        pin2Oe,	// Pin two driven while high.
	output logic                        protectActive,	// Latched protection state.
	output logic                        pinClearPulse,	// Pin cleared protection.
	output logic                        pin1Level,	// Detected logic on pin one.
	output logic                        pin2Level	// Detected logic on pin two.
);

	localparam int CW = $clog2(PULSE_CYC + 1);

	// Merges write data into a word under the byte enables.
	function automatic logic [31:0] beMerge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be
	);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return res;
	endfunction

	// Maps a logic value to a pin level; logic 1 is the low level uninverted.
	// The same mapping turns a pin level back into its logic value.
	function automatic logic pinLevel(input logic val, input logic inv);
		return inv ? val : ~val;
	endfunction

	// Logic value of a pin in general output mode.
	function automatic logic outValue(input ppl_osel_t sel, input logic wave);
		logic res;
		res = 1'b0;
		case (sel)
			PPL_OS_TRUE:  res = 1'b1;
			PPL_OS_FALSE: res = 1'b0;
			PPL_OS_PWM:   res = wave;
			default:      res = 1'b0;
		endcase
		return res;
	endfunction

	logic [31:0]  cfg_reg;
	logic [31:0]  cfg_next;
	logic [PW-1:0] p1Per_reg;
	logic [PW-1:0] p1Per_next;
	logic [PW-1:0] p1Duty_reg;
	logic [PW-1:0] p1Duty_next;
	logic [PW-1:0] p2Per_reg;
	logic [PW-1:0] p2Per_next;
	logic [PW-1:0] p2Duty_reg;
	logic [PW-1:0] p2Duty_next;
	logic [1:0]   ev_reg;
	logic [1:0]   ev_next;
	logic         waitReq_reg;
	logic         waitReq_next;
	logic [31:0]  readData_reg;
	logic [31:0]  readData_next;
	logic         protect_reg;
	logic         protect_next;
	logic         onPrev_reg;
	ppl_pulse_t   pulse_reg;
	ppl_pulse_t   pulse_next;
	logic [CW-1:0] outCnt_reg;
	logic [CW-1:0] outCnt_next;
	logic [CW-1:0] lowCnt_reg;
	logic [CW-1:0] lowCnt_next;
	logic         pin1Out_reg;
	logic         pin1Oe_reg;
	logic         pin2Out_reg;
	logic         pin2Oe_reg;
	logic         clrPulse_reg;
	logic         lvl1_reg;
	logic         lvl2_reg;
	logic [1:0]   pinSync;

	ppl_pwm_if #(.W(PW)) pwm1 ();
	ppl_pwm_if #(.W(PW)) pwm2 ();

	// Pins are asynchronous, so nothing below looks at them before two flops.
	ppl_pin_sync #(.W(2)) uSync (
		.clock (clock),
		.rst   (rst),
		.din   ({pin2In, pin1In}),
		.dout  (pinSync)
	);

	ppl_pwm #(.W(PW)) uPwm1 (
		.clock (clock),
		.rst   (rst),
		.bus   (pwm1.gen)
	);

	ppl_pwm #(.W(PW)) uPwm2 (
		.clock (clock),
		.rst   (rst),
		.bus   (pwm2.gen)
	);

	assign pwm1.period = p1Per_reg;
	assign pwm1.duty   = p1Duty_reg;
	assign pwm2.period = p2Per_reg;
	assign pwm2.duty   = p2Duty_reg;

	// Bus decode: a request is answered one cycle after it is first seen.
	wire reqNew  = (avs_read | avs_write) & waitReq_reg;
	wire wrAcc   = avs_write & ~waitReq_reg;
	wire selCfg  = (avs_address == `PPL_OFF_CFG);
	wire selP1P  = (avs_address == `PPL_OFF_P1PER);
	wire selP1D  = (avs_address == `PPL_OFF_P1DUTY);
	wire selP2P  = (avs_address == `PPL_OFF_P2PER);
	wire selP2D  = (avs_address == `PPL_OFF_P2DUTY);
	wire selStat = (avs_address == `PPL_OFF_STATUS);
	wire selEvt  = (avs_address == `PPL_OFF_EVENT);
	wire selCmd  = (avs_address == `PPL_OFF_CMD);

	// Configuration fields.
	wire ppl_func_t p1Func = ppl_func_t'(cfg_reg[`PPL_P1_FUNC_LSB +: 2]);
	wire ppl_func_t p2Func = ppl_func_t'(cfg_reg[`PPL_P2_FUNC_LSB +: 2]);
	wire ppl_osel_t p1Osel = ppl_osel_t'(cfg_reg[`PPL_P1_OSEL_LSB +: 2]);
	wire ppl_osel_t p2Osel = ppl_osel_t'(cfg_reg[`PPL_P2_OSEL_LSB +: 2]);
	wire            p1Inv  = cfg_reg[`PPL_P1_INV];
	wire            p2Inv  = cfg_reg[`PPL_P2_INV];

	// Logic values seen on the pins after inversion.
	wire p1InLogic = pinLevel(pinSync[0], p1Inv);
	wire p2InLogic = pinLevel(pinSync[1], p2Inv);

	// Pulse detection on pin one. Our own outgoing pulse is masked, otherwise
	// the device would clear itself with the pulse it sends.
	wire detEn    = (p1Func == PPL_FN_PROT) & ~pin1Oe_reg;
	wire lowSat   = (lowCnt_reg == CW'(PULSE_CYC));
	wire pulseOk  = detEn & p1InLogic & (lowCnt_reg == CW'(PULSE_CYC - 1));
	wire clrByPin = pulseOk & protect_reg & ~protectTrip;
	wire swClr    = wrAcc & selCmd & avs_byteenable[0] & avs_writedata[`PPL_CMD_CLR];

	// Count consecutive active-low samples; saturation makes a pulse fire once.
	assign lowCnt_next = (~detEn | ~p1InLogic) ? '0 :
			lowSat ? lowCnt_reg : (lowCnt_reg + {{(CW-1){1'b0}}, 1'b1});

	// A new trip wins over any clear in the same cycle.
	assign protect_next = protectTrip | (protect_reg & ~clrByPin & ~swClr);

	// Outgoing pulse starts on the switch going on with protection released.
	wire onRise     = outputOn & ~onPrev_reg;
	wire pulseStart = (pulse_reg == PPL_PULSE_IDLE) & onRise & ~protect_reg &
			(p1Func == PPL_FN_PROT);
	wire outLast    = (outCnt_reg == CW'(PULSE_CYC - 1));

	// Outgoing pulse sequencer; a change of function aborts the pulse.
	always_comb begin
		pulse_next  = pulse_reg;
		outCnt_next = outCnt_reg;
		case (pulse_reg)
			PPL_PULSE_IDLE: begin
				outCnt_next = '0;
				if (pulseStart) begin
					pulse_next = PPL_PULSE_DRIVE;
				end
			end
			PPL_PULSE_DRIVE: begin
				outCnt_next = outCnt_reg + {{(CW-1){1'b0}}, 1'b1};
				if (outLast || (p1Func != PPL_FN_PROT)) begin
					pulse_next  = PPL_PULSE_IDLE;
					outCnt_next = '0;
				end
			end
			default: begin
				pulse_next  = PPL_PULSE_IDLE;
				outCnt_next = '0;
			end
		endcase
	end

	// Pin one drive: pulses in clear mode, constant drive in output mode.
	wire p1Drive = (p1Func == PPL_FN_OUT) |
			((p1Func == PPL_FN_PROT) & (pulse_reg == PPL_PULSE_DRIVE));
	wire p1Logic = (p1Func == PPL_FN_OUT) ? outValue(p1Osel, pwm1.wave) : 1'b1;

	// Pin two drive: protection state, or output mode; input mode releases it.
	wire p2Drive = (p2Func == PPL_FN_PROT) | (p2Func == PPL_FN_OUT);
	wire p2Logic = (p2Func == PPL_FN_PROT) ? protect_reg :
			outValue(p2Osel, pwm2.wave);

	// Sticky events: the set wins over a write-one-to-clear in the same cycle.
	wire [1:0] evSet = {pulseStart, clrByPin};
	wire [1:0] evClr = (wrAcc & selEvt & avs_byteenable[0]) ? avs_writedata[1:0] : 2'h0;
	assign ev_next = (ev_reg & ~evClr) | evSet;

	// Register writes commit at the edge on which the master sees waitrequest low.
	// The PWM fields are sliced from named merged words, as a call cannot be indexed.
	wire [31:0] p1PerMrg  = beMerge(32'(p1Per_reg), avs_writedata, avs_byteenable);
	wire [31:0] p1DutyMrg = beMerge(32'(p1Duty_reg), avs_writedata, avs_byteenable);
	wire [31:0] p2PerMrg  = beMerge(32'(p2Per_reg), avs_writedata, avs_byteenable);
	wire [31:0] p2DutyMrg = beMerge(32'(p2Duty_reg), avs_writedata, avs_byteenable);
	assign cfg_next    = (wrAcc & selCfg) ?
			(beMerge(cfg_reg, avs_writedata, avs_byteenable) & `PPL_CFG_MASK) : cfg_reg;
	assign p1Per_next  = (wrAcc & selP1P) ?
			p1PerMrg[PW-1:0] : p1Per_reg;
	assign p1Duty_next = (wrAcc & selP1D) ?
			p1DutyMrg[PW-1:0] : p1Duty_reg;
	assign p2Per_next  = (wrAcc & selP2P) ?
			p2PerMrg[PW-1:0] : p2Per_reg;
	assign p2Duty_next = (wrAcc & selP2D) ?
			p2DutyMrg[PW-1:0] : p2Duty_reg;

	// Status shows live state; unmapped and write-only words read as zero.
	wire [31:0] statusWord =
			(32'(protect_reg) << `PPL_ST_PROT) |
			(32'(lvl1_reg) << `PPL_ST_IN1) |
			(32'(lvl2_reg) << `PPL_ST_IN2) |
			(32'(onPrev_reg) << `PPL_ST_OUTON) |
			(32'(pulse_reg == PPL_PULSE_DRIVE) << `PPL_ST_PULSE);
	wire [31:0] rdMux = selCfg  ? cfg_reg :
			selP1P  ? 32'(p1Per_reg) :
			selP1D  ? 32'(p1Duty_reg) :
			selP2P  ? 32'(p2Per_reg) :
			selP2D  ? 32'(p2Duty_reg) :
			selStat ? statusWord :
			selEvt  ? {30'h0, ev_reg} :
			32'h0;
	assign waitReq_next  = ~reqNew;
	assign readData_next = (avs_read & waitReq_reg) ? rdMux : readData_reg;

	// Bus handshake and register file.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			waitReq_reg  <= 1'b1;
			readData_reg <= 32'h0;
			cfg_reg      <= `PPL_CFG_RST;
			p1Per_reg    <= PW'(`PPL_PWM_RST);
			p1Duty_reg   <= PW'(`PPL_PWM_RST);
			p2Per_reg    <= PW'(`PPL_PWM_RST);
			p2Duty_reg   <= PW'(`PPL_PWM_RST);
			ev_reg       <= 2'h0;
		end else begin
			waitReq_reg  <= waitReq_next;
			readData_reg <= readData_next;
			cfg_reg      <= cfg_next;
			p1Per_reg    <= p1Per_next;
			p1Duty_reg   <= p1Duty_next;
			p2Per_reg    <= p2Per_next;
			p2Duty_reg   <= p2Duty_next;
			ev_reg       <= ev_next;
		end
	end

	// Protection latch, pulse detector and pulse sequencer.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			protect_reg  <= 1'b0;
			onPrev_reg   <= 1'b0;
			pulse_reg    <= PPL_PULSE_IDLE;
			outCnt_reg   <= '0;
			lowCnt_reg   <= CW'(PULSE_CYC);
			clrPulse_reg <= 1'b0;
		end else begin
			protect_reg  <= protect_next;
			onPrev_reg   <= outputOn;
			pulse_reg    <= pulse_next;
			outCnt_reg   <= outCnt_next;
			lowCnt_reg   <= lowCnt_next;
			clrPulse_reg <= clrByPin;
		end
	end

	// Registered pin drivers; the inversion applies to every level and pulse.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin1Out_reg <= 1'b1;
			pin1Oe_reg  <= 1'b0;
			pin2Out_reg <= 1'b1;
			pin2Oe_reg  <= 1'b0;
			lvl1_reg    <= 1'b0;
			lvl2_reg    <= 1'b0;
		end else begin
			pin1Out_reg <= pinLevel(p1Logic, p1Inv);
			pin1Oe_reg  <= p1Drive;
			pin2Out_reg <= pinLevel(p2Logic, p2Inv);
			pin2Oe_reg  <= p2Drive;
			lvl1_reg    <= p1InLogic;
			lvl2_reg    <= p2InLogic;
		end
	end

	assign avs_readdata    = readData_reg;
	assign avs_waitrequest = waitReq_reg;
	assign pin1Out         = pin1Out_reg;
	assign pin1Oe          = pin1Oe_reg;
	assign pin2Out         = pin2Out_reg;
	assign pin2Oe          = pin2Oe_reg;
	assign protectActive   = protect_reg;
	assign pinClearPulse   = clrPulse_reg;
	assign pin1Level       = lvl1_reg;
	assign pin2Level       = lvl2_reg;

endmodule // ppl_top
`default_nettype wire

/* File: tb/ppl_ext_inst.sv */
// Model of the external instrument on both pins, with pull-ups on the wires.
// Assumes the bench tells it when to pull a pin low.
`default_nettype none
module ppl_ext_inst (
	input  wire logic  clock,	// System clock.
	input  wire logic  rst,	// Reset, active high.
	input  wire logic  pin1Out,	// Level the block drives, pin one.
	input  wire logic  pin1Oe,	// Block drives pin one.
	input  wire logic  pin2Out,	// Level the block drives, pin two.
	input  wire logic  pin2Oe,	// Block drives pin two.
	input  wire logic  hold1Low,	// Instrument pulls pin one low.
	input  wire logic  hold2Low,	// Instrument pulls pin two low.
	output logic       pin1Wire,	// Resolved level, pin one.
	output logic       pin2Wire,	// Resolved level, pin two.
	output logic [15:0] lowWidth	// Clocks of the last low phase the block drove.
);
	logic [15:0] runReg;
	// Released wires sit high, so a pulse is always a high-to-low step.
	assign pin1Wire = pin1Oe ? pin1Out : !hold1Low;
	assign pin2Wire = pin2Oe ? pin2Out : !hold2Low;

	// Measures the low phase the block drives, so short outgoing pulses show.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			runReg <= 16'h0000;
			lowWidth <= 16'h0000;
		end else if (pin1Oe && !pin1Out) begin
			runReg <= runReg + 16'h0001;
		end else begin
			if (runReg != 16'h0000)
				lowWidth <= runReg;
			runReg <= 16'h0000;
		end
	end
endmodule // ppl_ext_inst
`default_nettype wire

/* File: tb/ppl_top_assertions.sv */
// Concurrent checks on the ports of the pin block.
// Assumes it is bound into ppl_top and that CFG is written with all byte lanes.
`default_nettype none
`include "ppl_consts.svh"
module ppl_top_assertions
	import ppl_pkg::*;
#(
	parameter int PULSE_CYC = 8	// Clocks of a valid pulse.
) (
	input wire logic                   clock,	// System clock.
	input wire logic                   rst,	// Reset, active high.
	input wire logic [`PPL_ADDR_W-1:0] avs_address,	// Byte address.
	input wire logic                   avs_read,	// Read request.
	input wire logic                   avs_write,	// Write request.
	input wire logic [31:0]            avs_writedata,	// Write data.
	input wire logic                   avs_waitrequest,	// Stall while high.
	input wire logic                   protectTrip,	// Protection event.
	input wire logic                   pin1In,	// Level on pin one.
	input wire logic                   pin1Out,	// Driven level, pin one.
	input wire logic                   pin1Oe,	// Pin one driven.
	input wire logic                   pin2Out,	// Driven level, pin two.
	input wire logic                   pin2Oe,	// Pin two driven.
	input wire logic                   protectActive,	// Latched protection.
	input wire logic                   pinClearPulse,	// Pin cleared protection.
	input wire logic                   pin1Level	// Detected logic, pin one.
);
	logic [12:0] cfgReg;
	logic [2:0]  ageReg;
	wire cfgHit = avs_write && !avs_waitrequest && avs_address == `PPL_OFF_CFG;

	// Shadow of the pin settings; the age keeps checks off while outputs still follow a write.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cfgReg <= 13'h0000;
			ageReg <= 3'h0;
		end else begin
			ageReg <= cfgHit ? 3'h0 : ageReg + {2'h0, ageReg != 3'h7};
			if (cfgHit)
				cfgReg <= avs_writedata[12:0] & 13'h1F1F;
		end
	end

	a_wait_one: assert property (@(posedge clock) disable iff (rst)
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("bus answer not one cycle long");
	a_trip_sets: assert property (@(posedge clock) disable iff (rst)
		protectTrip |=> protectActive)
		else $error("protection not latched");
	a_clear_once: assert property (@(posedge clock) disable iff (rst)
		pinClearPulse |=> !pinClearPulse)
		else $error("clear event longer than one cycle");
	a_clear_drops: assert property (@(posedge clock) disable iff (rst)
		pinClearPulse |-> !protectActive && $past(protectActive) && !$past(pin1Oe))
		else $error("clear event without release of protection");
	a_state_level: assert property (@(posedge clock) disable iff (rst)
		ageReg != 3'h0 && cfgReg[9:8] == 2'h0
		|-> pin2Oe && pin2Out == (!$past(protectActive) ^ cfgReg[10]))
		else $error("state pin level wrong");
	a_out_pin1: assert property (@(posedge clock) disable iff (rst)
		ageReg != 3'h0 && cfgReg[1:0] == 2'h2 && !cfgReg[4]
		|-> pin1Oe && pin1Out == (!cfgReg[3] ^ cfgReg[2]))
		else $error("pin one output level wrong");
	a_out_pin2: assert property (@(posedge clock) disable iff (rst)
		ageReg != 3'h0 && cfgReg[9:8] == 2'h2 && !cfgReg[12]
		|-> pin2Oe && pin2Out == (!cfgReg[11] ^ cfgReg[10]))
		else $error("pin two output level wrong");
	a_in_release: assert property (@(posedge clock) disable iff (rst)
		ageReg != 3'h0 && cfgReg[1:0] == 2'h1 |-> !pin1Oe)
		else $error("pin one driven in input mode");
	a_in_level: assert property (@(posedge clock) disable iff (rst)
		ageReg > 3'h3 && cfgReg[1:0] == 2'h1 |-> pin1Level == (!$past(pin1In, 3) ^ cfgReg[2]))
		else $error("pin one detected level wrong");
endmodule // ppl_top_assertions

bind ppl_top ppl_top_assertions #(.PULSE_CYC(PULSE_CYC)) u_chk (.clock(clock), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.protectTrip(protectTrip), .pin1In(pin1In), .pin1Out(pin1Out), .pin1Oe(pin1Oe),
	.pin2Out(pin2Out), .pin2Oe(pin2Oe), .protectActive(protectActive),
	.pinClearPulse(pinClearPulse), .pin1Level(pin1Level));
`default_nettype wire

/* File: tb/ppl_top_bench.sv */
// Self-checking bench of the pin block: bus tasks, pin stimulus, comparisons.
// Assumes the instrument model and the bound checker are compiled alongside.
`default_nettype none
`include "ppl_consts.svh"
module ppl_top_bench import ppl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PC = 8;	// Short pulse count keeps the run brief.
	logic        clock = 1'b0, rst = 1'b1, readReq = 1'b0, writeReq = 1'b0;
	logic [4:0]  address = 5'h00;
	logic [31:0] wData = 32'h0000_0000, rData, junk;
	logic        waitReq, trip = 1'b0, outOn = 1'b0, hold1Low = 1'b0, hold2Low = 1'b0;
	logic        pin1Wire, pin2Wire, pin1Out, pin1Oe, pin2Out, pin2Oe, prot, clrPulse;
	logic        lvl1, lvl2;
	logic [15:0] lowWidth;
	logic [4:0]  fld;
	int          err_count = 0, n_compared = 0, clrSeen = 0, lowCnt;

	always #20 clock = ~clock;
	always @(posedge clock) if (clrPulse === 1'b1) clrSeen++;

	ppl_top #(.PULSE_CYC(PC)) u_dut (.clock(clock), .rst(rst), .avs_address(address),
		.avs_read(readReq), .avs_write(writeReq), .avs_writedata(wData),
		.avs_byteenable(4'hF), .avs_readdata(rData), .avs_waitrequest(waitReq),
		.protectTrip(trip), .outputOn(outOn), .pin1In(pin1Wire), .pin1Out(pin1Out),
		.pin1Oe(pin1Oe), .pin2In(pin2Wire), .pin2Out(pin2Out), .pin2Oe(pin2Oe),
		.protectActive(prot), .pinClearPulse(clrPulse), .pin1Level(lvl1), .pin2Level(lvl2));
	ppl_ext_inst u_ext (.clock(clock), .rst(rst), .pin1Out(pin1Out), .pin1Oe(pin1Oe),
		.pin2Out(pin2Out), .pin2Oe(pin2Oe), .hold1Low(hold1Low), .hold2Low(hold2Low),
		.pin1Wire(pin1Wire), .pin2Wire(pin2Wire), .lowWidth(lowWidth));

	task automatic summarize();
		if (err_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	// One bus cycle; the request stands until waitrequest is seen low at an edge.
	task automatic busOp(input logic wrOp, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clock);
		address <= a;
		wData <= d;
		writeReq <= wrOp;
		readReq <= !wrOp;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waitReq !== 1'b0 && n < 50);
		if (n >= 50) begin
			err_count++;
			summarize();
		end
		q = rData;
		writeReq <= 1'b0;
		readReq <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		busOp(1'b1, a, d, junk);
	endtask

	task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
		busOp(1'b0, a, 32'h0000_0000, junk);
		check(junk, exp);
	endtask

	// The instrument holds pin one low for w clocks, then lets it rise.
	task automatic extPulse(input int w);
		@(posedge clock);
		hold1Low <= 1'b1;
		repeat (w) @(posedge clock);
		hold1Low <= 1'b0;
		repeat (8) @(posedge clock);
	endtask

	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		check(pin2Wire, 1'b1);
		check(pin1Oe, 1'b0);
		rdChk(`PPL_OFF_CFG, 32'h0000_0000);
		rdChk(`PPL_OFF_CMD, 32'h0000_0000);
		// Protection shows on the state pin, then the inverted view.
		trip <= 1'b1;
		@(posedge clock);
		trip <= 1'b0;
		repeat (2) @(posedge clock);
		check(pin2Wire, 1'b0);
		wr(`PPL_OFF_CFG, 32'h0000_0400);
		repeat (2) @(posedge clock);
		check(pin2Wire, 1'b1);
		wr(`PPL_OFF_CFG, 32'h0000_0000);
		// A pulse too short is ignored; a long one clears exactly once.
		extPulse(PC - 2);
		check(prot, 1'b1);
		extPulse(PC + 4);
		check(prot, 1'b0);
		check(clrSeen, 1);
		// Switching the output on after release sends one pulse of full width.
		outOn <= 1'b1;
		repeat (PC + 8) @(posedge clock);
		check(lowWidth, PC);
		check(pin1Oe, 1'b0);
		outOn <= 1'b0;
		rdChk(`PPL_OFF_EVENT, 32'h0000_0003);
		wr(`PPL_OFF_EVENT, 32'h0000_0003);
		rdChk(`PPL_OFF_EVENT, 32'h0000_0000);
		// The software clear command releases a fresh trip and raises no pin event.
		trip <= 1'b1;
		@(posedge clock);
		trip <= 1'b0;
		@(posedge clock);
		check(prot, 1'b1);
		wr(`PPL_OFF_CMD, 32'h0000_0001);
		@(posedge clock);
		check(prot, 1'b0);
		rdChk(`PPL_OFF_EVENT, 32'h0000_0000);
		// Fixed output levels on both pins, both polarities.
		for (int i = 0; i < 8; i++) begin
			fld = {1'b0, i[0], i[1], 2'h2};
			wr(`PPL_OFF_CFG, i[2] ? {19'h0, fld, 8'h00} : {27'h0, fld});
			repeat (2) @(posedge clock);
			check(i[2] ? pin2Wire : pin1Wire, !i[0] ^ i[1]);
		end
		// A wave of period four with one clock at logic 1 is low a quarter of the time.
		wr(`PPL_OFF_P1PER, 32'h0000_0004);
		wr(`PPL_OFF_P1DUTY, 32'h0000_0001);
		wr(`PPL_OFF_CFG, 32'h0000_0012);
		repeat (8) @(posedge clock);
		lowCnt = 0;
		repeat (40) begin
			@(posedge clock);
			lowCnt += !pin1Wire;
		end
		check(lowCnt, 10);
		// Level inputs report the logic value, inverted on request.
		wr(`PPL_OFF_CFG, 32'h0000_0101);
		hold1Low <= 1'b1;
		repeat (5) @(posedge clock);
		check({lvl2, lvl1}, 2'h1);
		rdChk(`PPL_OFF_STATUS, 32'h0000_0002);
		wr(`PPL_OFF_CFG, 32'h0000_0105);
		repeat (5) @(posedge clock);
		check(lvl1, 1'b0);
		hold1Low <= 1'b0;
		summarize();
	end
endmodule // ppl_top_bench
`default_nettype wire
